/* File: design/tmc8_timer.sv */
// Contract
// - bottom detected when count is 0x00
// - max detected when count is 0xff
// - top is 0xff or compare value, by mode
// - tick is io clock tick, or oscillator pin when async selected
// - counter clears, counts up or down per tick; stops when select is 0
// - software may read and write the count at any time
// - software write to count beats clear or count
// - two-bit mode field picks sequence; overflow flag set per mode
// - comparator flags equality of count and active compare value
// - match flag set on the tick after the match
// - enabled match flag raises compare interrupt request
// - match flag clears on service or by writing one
// - compare value double buffered in pwm modes only
// - accesses reach buffer when buffered, active value otherwise
// - force strobe acts on output bit only in non-pwm modes
// - count write blocks matches on next tick, even stopped
// - output bit holds across mode changes
// - output mode field unbuffered, used at the next match
// - nonzero output mode routes output bit to pin; direction kept
// - pin override independent of waveform mode
// - output mode 0 leaves output bit alone at match
// - mode 0 counts up, wraps, sets overflow on becoming zero
// - mode 2 clears count on compare match
// - clear-on-match with output mode 1 toggles output bit
`include "tmc8_params.svh"

module tmc8_timer (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// register port
	input  wire tmc8_pkg::tmc8_bus_type bus,
	output logic [7:0]                 rdata,
	// tick sources
	input  wire logic                  prescale_tick,
	input  wire logic                  osc_pin_in,
	// interrupt handshake
	input  wire logic                  cmp_irq_ack,
	input  wire logic                  ovf_irq_ack,
	output logic                       cmp_irq_req,
	output logic                       ovf_flag_out,
	// port pin
	input  wire logic                  port_out_val,
	output tmc8_pkg::tmc8_pin_type     pin
);
	import tmc8_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0]   clock_select_field;
	tmc8_wgm_type waveform_mode_field;
	logic [1:0]   compare_output_mode_field;
	logic [7:0]   timer_count_value;
	logic [7:0]   compare_value_reg;
	logic [7:0]   cmp_buffer_r;
	logic         compare_match_flag;
	logic         overflow_flag;
	logic         compare_irq_enable;
	logic         async_clock_select;
	logic         output_pin_direction_bit;
	logic         compare_output_bit;
	logic         block_match_r;
	logic         match_pend_r;
	logic         dir_down_r;
	logic         timer_tick;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic is_pwm(input tmc8_wgm_type m);
		is_pwm = (m == TMC8_WGM_PWM_PC) || (m == TMC8_WGM_PWM_FAST);
	endfunction

	function automatic logic hit(input logic [3:0] a);
		hit = bus.addr == a;
	endfunction

	// flag clear: serviced interrupt, or a one written to the flag's own bit
	function automatic logic clear_req(input logic ack, input int bit_pos);
		clear_req = ack || (bus.wr && hit(`TMC8_ADDR_FLAGS) && bus.wdata[bit_pos]);
	endfunction

	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp;
	logic wr_flags;
	logic wr_irqen;
	logic wr_async;
	logic wr_port;
	logic force_hit;
	logic at_bottom;
	logic at_max;
	logic at_top;
	logic match;
	logic eff_match;
	logic [7:0] top_value;
	logic buffered;

	assign wr_ctrl  = bus.wr && hit(`TMC8_ADDR_CTRL);
	assign wr_count = bus.wr && hit(`TMC8_ADDR_COUNT);
	assign wr_cmp   = bus.wr && hit(`TMC8_ADDR_CMP);
	assign wr_flags = bus.wr && hit(`TMC8_ADDR_FLAGS);
	assign wr_irqen = bus.wr && hit(`TMC8_ADDR_IRQEN);
	assign wr_async = bus.wr && hit(`TMC8_ADDR_ASYNC);
	assign wr_port  = bus.wr && hit(`TMC8_ADDR_PORT);
	assign buffered = is_pwm(waveform_mode_field);

	assign force_hit = wr_ctrl && bus.wdata[`TMC8_CTRL_FOC_BIT] && !buffered;

	assign at_bottom = timer_count_value == `TMC8_BOTTOM;
	assign at_max    = timer_count_value == `TMC8_MAX;
	// top select
	// only clear-on-match tops out at the compare value; both pwm modes run to max here
	assign top_value = (waveform_mode_field == TMC8_WGM_CTC) ? compare_value_reg : `TMC8_MAX;
	assign at_top    = timer_count_value == top_value;
	assign match     = timer_count_value == compare_value_reg;
	assign eff_match = match && !block_match_r;

	// ----------------------------------------------------------------
	// tick source
	// ----------------------------------------------------------------
	tmc8_tick_sel u_tick (
		.clk                (clk),
		.rst                (rst),
		.clock_select_field (clock_select_field),
		.async_clock_select (async_clock_select),
		.prescale_tick      (prescale_tick),
		.osc_pin_in         (osc_pin_in),
		.timer_tick         (timer_tick)
	);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// stopped after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clock_select_field        <= `TMC8_RST_CS;
			waveform_mode_field       <= TMC8_WGM_NORMAL;
			compare_output_mode_field <= 2'h0;
		end else if (wr_ctrl) begin
			clock_select_field <= bus.wdata[`TMC8_CTRL_CS_LSB +: 3];
			waveform_mode_field <= tmc8_wgm_type'({bus.wdata[`TMC8_CTRL_WGM1_BIT],
					bus.wdata[`TMC8_CTRL_WGM0_BIT]});
			compare_output_mode_field <= bus.wdata[`TMC8_CTRL_COM_LSB +: 2];
		end
	end

	// compare interrupt enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			compare_irq_enable <= 1'b0;
		else if (wr_irqen)
			compare_irq_enable <= bus.wdata[`TMC8_FLAG_CMP_BIT];
	end

	// oscillator source select
	// switching sources may give one stray tick; stop the timer first
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			async_clock_select <= 1'b0;
		else if (wr_async)
			async_clock_select <= bus.wdata[`TMC8_AS_BIT];
	end

	// pin direction bit
	// pin stays undriven until software sets this, so the bit can be preset first
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			output_pin_direction_bit <= 1'b0;
		else if (wr_port)
			output_pin_direction_bit <= bus.wdata[`TMC8_PORT_DIR_BIT];
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// direction for phase correct: down after top, up after bottom
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_down_r <= 1'b0;
		end else if (waveform_mode_field != TMC8_WGM_PWM_PC) begin
			dir_down_r <= 1'b0;
		end else if (timer_tick && !wr_count) begin
			if (at_top)
				dir_down_r <= 1'b1;
			else if (at_bottom)
				dir_down_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_count_value <= `TMC8_RST_BYTE;
		end else if (wr_count) begin
			timer_count_value <= bus.wdata;
		end else if (timer_tick) begin
			if (waveform_mode_field == TMC8_WGM_CTC && eff_match)
				timer_count_value <= `TMC8_BOTTOM; // clear on match
			else if (waveform_mode_field == TMC8_WGM_PWM_PC &&
					(dir_down_r ? !at_bottom : at_max))
				timer_count_value <= timer_count_value - 8'h01;
			else
				timer_count_value <= timer_count_value + 8'h01; // wraps
		end
	end

	// count write blocks the match of the following tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			block_match_r <= 1'b0;
		else if (wr_count)
			block_match_r <= 1'b1;
		else if (timer_tick)
			block_match_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// compare registers
	// ----------------------------------------------------------------
	// access steering
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cmp_buffer_r <= `TMC8_RST_BYTE;
		else if (wr_cmp)
			cmp_buffer_r <= bus.wdata;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			compare_value_reg <= `TMC8_RST_BYTE;
		else if (!buffered && wr_cmp)
			compare_value_reg <= bus.wdata;
		else if (!buffered)
			compare_value_reg <= compare_value_reg;
		else if (timer_tick && ((waveform_mode_field == TMC8_WGM_PWM_FAST && at_max) ||
				(waveform_mode_field == TMC8_WGM_PWM_PC && at_max)))
			compare_value_reg <= cmp_buffer_r;
	end

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	// match seen on this tick, flagged on the next tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			match_pend_r <= 1'b0;
		else if (timer_tick)
			match_pend_r <= eff_match;
	end

	// clear on ack or write one; set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			compare_match_flag <= 1'b0;
		else if (timer_tick && match_pend_r)
			compare_match_flag <= 1'b1;
		else if (clear_req(cmp_irq_ack, `TMC8_FLAG_CMP_BIT))
			compare_match_flag <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			overflow_flag <= 1'b0;
		else if (timer_tick && !wr_count &&
				((waveform_mode_field == TMC8_WGM_PWM_PC) ? (at_bottom && dir_down_r)
				: at_max))
			overflow_flag <= 1'b1;
		else if (clear_req(ovf_irq_ack, `TMC8_FLAG_OVF_BIT))
			overflow_flag <= 1'b0;
	end

	assign cmp_irq_req  = compare_match_flag && compare_irq_enable;
	assign ovf_flag_out = overflow_flag;

	// ----------------------------------------------------------------
	// waveform output bit
	// ----------------------------------------------------------------
	// no reset on mode change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_output_bit <= 1'b0;
		end else if (force_hit || (timer_tick && eff_match && !buffered)) begin
			case (compare_output_mode_field)
				2'h1: compare_output_bit <= ~compare_output_bit; // toggle
				2'h2: compare_output_bit <= 1'b0;
				2'h3: compare_output_bit <= 1'b1;
				default: compare_output_bit <= compare_output_bit;
			endcase
		end else if (timer_tick && buffered) begin
			// pwm: compare mode 2 clears on match, sets at bottom when counting up; 3 inverted
			if (compare_output_mode_field[1] && eff_match)
				compare_output_bit <= compare_output_mode_field[0];
			else if (compare_output_mode_field[1] && at_bottom && !dir_down_r)
				compare_output_bit <= ~compare_output_mode_field[0];
		end
	end

	assign pin.pin_out = (|compare_output_mode_field) ? compare_output_bit : port_out_val;
	assign pin.pin_oe  = output_pin_direction_bit;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= `TMC8_RST_BYTE;
		end else if (bus.rd) begin
			case (bus.addr)
				`TMC8_ADDR_CTRL:  rdata <= {1'b0, waveform_mode_field[0],
						compare_output_mode_field, waveform_mode_field[1], clock_select_field};
				`TMC8_ADDR_COUNT: rdata <= timer_count_value;
				`TMC8_ADDR_CMP:   rdata <= buffered ? cmp_buffer_r : compare_value_reg;
				`TMC8_ADDR_FLAGS: rdata <= {6'h00, compare_match_flag, overflow_flag};
				`TMC8_ADDR_IRQEN: rdata <= {6'h00, compare_irq_enable, 1'b0};
				`TMC8_ADDR_ASYNC: rdata <= {4'h0, async_clock_select, 3'h0};
				`TMC8_ADDR_PORT:  rdata <= {6'h00, output_pin_direction_bit, 1'b0};
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

/* File: design/tmc8_params.svh */
`ifndef TMC8_PARAMS_SVH
`define TMC8_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TMC8_ADDR_CTRL   4'h0
`define TMC8_ADDR_COUNT  4'h1
`define TMC8_ADDR_CMP    4'h2
`define TMC8_ADDR_FLAGS  4'h3
`define TMC8_ADDR_IRQEN  4'h4
`define TMC8_ADDR_ASYNC  4'h5
`define TMC8_ADDR_PORT   4'h6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TMC8_CTRL_CS_LSB   0
`define TMC8_CTRL_WGM1_BIT 3
`define TMC8_CTRL_COM_LSB  4
`define TMC8_CTRL_WGM0_BIT 6
`define TMC8_CTRL_FOC_BIT  7

// ----------------------------------------------------------------
// flag, enable and port fields
// ----------------------------------------------------------------
`define TMC8_FLAG_CMP_BIT  1
`define TMC8_FLAG_OVF_BIT  0
`define TMC8_AS_BIT        3
`define TMC8_PORT_VAL_BIT  0
`define TMC8_PORT_DIR_BIT  1

// ----------------------------------------------------------------
// count values and reset values
// ----------------------------------------------------------------
`define TMC8_BOTTOM     8'h00
`define TMC8_MAX        8'hff
`define TMC8_RST_BYTE   8'h00
`define TMC8_RST_CS     3'h0

`endif

/* File: design/tmc8_pkg.sv */
package tmc8_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TMC8_WGM_NORMAL,
		TMC8_WGM_PWM_PC,
		TMC8_WGM_CTC,
		TMC8_WGM_PWM_FAST
	} tmc8_wgm_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmc8_bus_type;

	typedef struct packed {
		logic pin_out;
		logic pin_oe;
	} tmc8_pin_type;

endpackage

/* File: design/tmc8_tick_sel.sv */
`include "tmc8_params.svh"

// ----------------------------------------------------------------
// timer tick selection
// ----------------------------------------------------------------
module tmc8_tick_sel (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// selection
	input  wire logic [2:0] clock_select_field,
	input  wire logic       async_clock_select,
	// sources
	input  wire logic       prescale_tick,
	input  wire logic       osc_pin_in,
	// result
	output logic            timer_tick
);

	logic osc_s1_r;
	logic osc_s2_r;
	logic osc_s3_r;

	// oscillator sync; stages two and three feed the edge detector
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= osc_pin_in;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	always_comb begin
		if (clock_select_field == `TMC8_RST_CS)
			timer_tick = 1'b0;
		else if (async_clock_select)
			timer_tick = osc_s2_r & ~osc_s3_r;
		else
			timer_tick = prescale_tick;
	end

endmodule

/* File: dv/tmc8_timer_chk.sv */
`include "tmc8_params.svh"

module tmc8_timer_chk (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// register port
	input wire tmc8_pkg::tmc8_bus_type bus,
	input wire logic [7:0]             rdata,
	// tick sources
	input wire logic                   prescale_tick,
	input wire logic                   osc_pin_in,
	// interrupt handshake
	input wire logic                   cmp_irq_ack,
	input wire logic                   ovf_irq_ack,
	input wire logic                   cmp_irq_req,
	input wire logic                   ovf_flag_out,
	// port pin
	input wire logic                   port_out_val,
	input wire tmc8_pkg::tmc8_pin_type pin
);
	timeunit 1ns;
	timeprecision 1ns;
	import tmc8_pkg::*;

	logic [3:0] osc_hist_r;
	logic       quiet;

	// oscillator history: a synced edge lands a few clocks after the pin moves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_hist_r <= 4'h0;
		end else begin
			osc_hist_r <= {osc_hist_r[2:0], osc_pin_in};
		end
	end
	// no tick can be in flight from either source
	assign quiet = ~|{osc_hist_r, osc_pin_in, prescale_tick};

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_unmapped_read: assert property (bus.rd && bus.addr > `TMC8_ADDR_PORT |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_flags_read: assert property (bus.rd && bus.addr == `TMC8_ADDR_FLAGS
		|=> rdata[0] == $past(ovf_flag_out)) else $error("overflow bit misread");
	a_dir_write: assert property (bus.wr && bus.addr == `TMC8_ADDR_PORT
		|=> pin.pin_oe == $past(bus.wdata[1])) else $error("pin direction not written");
	a_dir_hold: assert property (!(bus.wr && bus.addr == `TMC8_ADDR_PORT) |=> $stable(pin.pin_oe))
		else $error("pin direction moved");
	a_cmp_clear: assert property ((cmp_irq_ack || (bus.wr && bus.addr == `TMC8_ADDR_FLAGS
		&& bus.wdata[1])) && quiet |=> !cmp_irq_req) else $error("compare flag not cleared");
	a_ovf_clear: assert property ((ovf_irq_ack || (bus.wr && bus.addr == `TMC8_ADDR_FLAGS
		&& bus.wdata[0])) && quiet |=> !ovf_flag_out) else $error("overflow flag not cleared");
	a_ovf_rise: assert property ($rose(ovf_flag_out) |-> !$past(quiet))
		else $error("overflow set without tick");
	a_req_rise: assert property ($rose(cmp_irq_req) |-> !$past(quiet) || $past(bus.wr))
		else $error("compare request without cause");
	a_req_stays: assert property (cmp_irq_req && !cmp_irq_ack && !bus.wr |=> cmp_irq_req)
		else $error("compare request dropped");
endmodule

bind tmc8_timer tmc8_timer_chk u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
	.prescale_tick(prescale_tick), .osc_pin_in(osc_pin_in), .cmp_irq_ack(cmp_irq_ack),
	.ovf_irq_ack(ovf_irq_ack), .cmp_irq_req(cmp_irq_req), .ovf_flag_out(ovf_flag_out),
	.port_out_val(port_out_val), .pin(pin));

/* File: dv/tmc8_cpu_model.sv */
module tmc8_cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic service_en,
	input wire logic slow,
	// requests and acknowledges
	input wire logic cmp_irq_req,
	input wire logic ovf_flag_out,
	output logic     cmp_irq_ack,
	output logic     ovf_irq_ack
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] wait_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_r <= 3'h0;
			cmp_irq_ack <= 1'b0;
			ovf_irq_ack <= 1'b0;
		end else begin
			cmp_irq_ack <= 1'b0;
			ovf_irq_ack <= 1'b0;
			if (!service_en || !(cmp_irq_req || ovf_flag_out) || cmp_irq_ack || ovf_irq_ack) begin
				wait_r <= 3'h0;
			end else if (wait_r == (slow ? 3'h5 : 3'h0)) begin
				cmp_irq_ack <= cmp_irq_req;
				ovf_irq_ack <= ovf_flag_out;
				wait_r <= 3'h0;
			end else begin
				wait_r <= wait_r + 3'h1;
			end
		end
	end
endmodule

/* File: dv/timer8_compare_unit_bench.sv */
`include "tmc8_params.svh"

module timer8_compare_unit_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import tmc8_pkg::*;

	logic         clk = 1'b0;
	logic         rst = 1'b1;
	tmc8_bus_type bus = '0;
	logic [7:0]   rdata;
	logic         prescale_tick = 1'b0;
	logic         osc_pin_in = 1'b0;
	logic         port_out_val = 1'b0;
	logic         service_en = 1'b0;
	logic         slow = 1'b0;
	logic         cmp_irq_ack;
	logic         ovf_irq_ack;
	logic         cmp_irq_req;
	logic         ovf_flag_out;
	tmc8_pin_type pin;
	logic [31:0]  seed = 32'haf6bf1a3;
	logic [7:0]   v;
	logic [7:0]   t;
	int           fails = 0;
	int           n_compared = 0;
	int           cyc = 0;

	// 10 MHz clock
	always #50 clk = ~clk;

	tmc8_timer dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .prescale_tick(prescale_tick),
		.osc_pin_in(osc_pin_in), .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
		.cmp_irq_req(cmp_irq_req), .ovf_flag_out(ovf_flag_out), .port_out_val(port_out_val),
		.pin(pin));
	tmc8_cpu_model cpu (.clk(clk), .rst(rst), .service_en(service_en), .slow(slow),
		.cmp_irq_req(cmp_irq_req), .ovf_flag_out(ovf_flag_out), .cmp_irq_ack(cmp_irq_ack),
		.ovf_irq_ack(ovf_irq_ack));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] ctl(input logic [1:0] w, input logic [1:0] m, input logic [2:0] s);
		return {1'b0, w[0], m, w[1], s};
	endfunction
	// count after n ticks when the sequence tops out at top
	function automatic logic [7:0] after(input logic [7:0] c, input logic [7:0] top, input int n);
		repeat (n) c = (c == top) ? 8'h00 : c + 8'h01;
		return c;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one strobe cycle, then one idle cycle so strobes never merge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input string m);
		logic [7:0] g;
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 g = rdata;
		@(posedge clk);
		chk(g, e, m);
	endtask
	// tick pulses with random gaps
	task automatic tick(input int n);
		repeat (n) begin
			prescale_tick <= 1'b1;
			@(posedge clk);
			prescale_tick <= 1'b0;
			repeat (1 + seed[1:0]) @(posedge clk);
			seed = lfsr(seed);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(`TMC8_ADDR_COUNT, 8'h00, "count reset");
		rc(`TMC8_ADDR_CMP, 8'h00, "compare reset");
		rc(`TMC8_ADDR_FLAGS, 8'h00, "flags reset");
		chk({7'h0, pin.pin_oe}, 8'h00, "dir reset");
		v = seed[7:0];
		wr(`TMC8_ADDR_COUNT, v);
		rc(`TMC8_ADDR_COUNT, v, "count rw");
		rc(4'hf, 8'h00, "unmapped");
		tick(3);
		rc(`TMC8_ADDR_COUNT, v, "stopped");
		$display("end access");
		wr(`TMC8_ADDR_CMP, 8'h80);
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd0, 3'd1));
		wr(`TMC8_ADDR_COUNT, 8'hfe);
		tick(1);
		rc(`TMC8_ADDR_FLAGS, 8'h00, "early overflow");
		tick(1);
		rc(`TMC8_ADDR_COUNT, after(8'hfe, 8'hff, 2), "wrap");
		rc(`TMC8_ADDR_FLAGS, 8'h01, "overflow");
		wr(`TMC8_ADDR_FLAGS, 8'h01);
		rc(`TMC8_ADDR_FLAGS, 8'h00, "overflow clear");
		$display("end normal");
		t = {5'h0, seed[2:0]} + 8'h02;
		wr(`TMC8_ADDR_CMP, t);
		wr(`TMC8_ADDR_CTRL, ctl(2'd2, 2'd1, 3'd1));
		rc(`TMC8_ADDR_CTRL, ctl(2'd2, 2'd1, 3'd1), "ctrl read");
		wr(`TMC8_ADDR_COUNT, 8'h00);
		tick(int'(t) + 1);
		rc(`TMC8_ADDR_FLAGS, 8'h00, "flag too early");
		tick(1);
		rc(`TMC8_ADDR_COUNT, after(8'h00, t, int'(t) + 2), "ctc clear");
		rc(`TMC8_ADDR_FLAGS, 8'h02, "match flag");
		chk({7'h0, pin.pin_out}, 8'h01, "toggle");
		wr(`TMC8_ADDR_FLAGS, 8'h02);
		wr(`TMC8_ADDR_COUNT, t);
		tick(2);
		rc(`TMC8_ADDR_COUNT, t + 8'h02, "blocked clear");
		rc(`TMC8_ADDR_FLAGS, 8'h00, "blocked flag");
		wr(`TMC8_ADDR_CTRL, ctl(2'd2, 2'd1, 3'd1) | 8'h80);
		chk({7'h0, pin.pin_out}, 8'h00, "force toggle");
		rc(`TMC8_ADDR_FLAGS, 8'h00, "force flag");
		rc(`TMC8_ADDR_COUNT, t + 8'h02, "force count");
		$display("end ctc");
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd1, 3'd0));
		chk({7'h0, pin.pin_out}, 8'h00, "mode change");
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd1, 3'd0) | 8'h80);
		chk({7'h0, pin.pin_out}, 8'h01, "normal override");
		wr(`TMC8_ADDR_CTRL, 8'h00);
		repeat (4) begin
			port_out_val <= seed[0];
			seed = lfsr(seed);
			@(negedge clk);
			chk({7'h0, pin.pin_out}, {7'h0, port_out_val}, "port value");
			@(posedge clk);
		end
		wr(`TMC8_ADDR_CTRL, ctl(2'd2, 2'd0, 3'd1));
		wr(`TMC8_ADDR_COUNT, 8'h00);
		tick(int'(t) + 2);
		wr(`TMC8_ADDR_CTRL, ctl(2'd2, 2'd1, 3'd0));
		chk({7'h0, pin.pin_out}, 8'h01, "mode zero idle");
		wr(`TMC8_ADDR_PORT, 8'h02);
		chk({7'h0, pin.pin_oe}, 8'h01, "pin dir");
		$display("end pin");
		wr(`TMC8_ADDR_IRQEN, 8'h02);
		chk({7'h0, cmp_irq_req}, 8'h01, "irq raised");
		slow <= seed[0];
		service_en <= 1'b1;
		for (int i = 0; i < 20 && cmp_irq_req !== 1'b0; i++) @(negedge clk);
		chk({7'h0, cmp_irq_req}, 8'h00, "serviced");
		@(posedge clk);
		service_en <= 1'b0;
		$display("end irq");
		wr(`TMC8_ADDR_IRQEN, 8'h00);
		wr(`TMC8_ADDR_ASYNC, 8'h08);
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd0, 3'd1));
		wr(`TMC8_ADDR_COUNT, 8'h00);
		tick(2);
		repeat (3) begin
			osc_pin_in <= 1'b1;
			repeat (3) @(posedge clk);
			osc_pin_in <= 1'b0;
			repeat (3) @(posedge clk);
		end
		rc(`TMC8_ADDR_COUNT, after(8'h00, 8'hff, 3), "async ticks");
		$display("end async");
		wr(`TMC8_ADDR_ASYNC, 8'h00);
		wr(`TMC8_ADDR_CTRL, ctl(2'd3, 2'd1, 3'd0));
		wr(`TMC8_ADDR_CTRL, ctl(2'd3, 2'd1, 3'd0) | 8'h80);
		chk({7'h0, pin.pin_out}, 8'h01, "pwm force ignored");
		wr(`TMC8_ADDR_CMP, 8'h40);
		rc(`TMC8_ADDR_CMP, 8'h40, "pwm buffer");
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd0, 3'd0));
		rc(`TMC8_ADDR_CMP, t, "active kept");
		wr(`TMC8_ADDR_CTRL, ctl(2'd3, 2'd0, 3'd1));
		wr(`TMC8_ADDR_COUNT, 8'hfe);
		tick(2);
		rc(`TMC8_ADDR_COUNT, after(8'hfe, 8'hff, 2), "pwm wrap");
		wr(`TMC8_ADDR_CTRL, ctl(2'd0, 2'd0, 3'd0));
		rc(`TMC8_ADDR_CMP, 8'h40, "loaded at max");
		// dual slope: fe, up to max, then back down twice
		wr(`TMC8_ADDR_CTRL, ctl(2'd1, 2'd0, 3'd1));
		wr(`TMC8_ADDR_COUNT, 8'hfe);
		tick(3);
		rc(`TMC8_ADDR_COUNT, 8'hfd, "dual slope");
		$display("end pwm");
		complete_run();
	end
endmodule
